// ---- src/adc_ctrl_pkg.sv ----
// Purpose: Shared constants and types for the converter result and sleep control block
// Assumes: Converter clock ticks are derived from core_clk_in by a prescaler
// Notes:   Tick counts are in converter clock cycles
package adc_ctrl_pkg;
    // ------------------------------------------------------------------
    // Widths and result codes
    // ------------------------------------------------------------------
    localparam int RESULT_W = 10;
    localparam logic [9:0] CODE_ZERO = 10'h000;
    localparam logic [9:0] CODE_FULL = 10'h3ff;
    localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
    localparam logic [3:0] SAR_TOP_BIT = 4'h9;
    localparam logic [15:0] BYTES_RESET = 16'h0000;
    // ------------------------------------------------------------------
    // Conversion timing, converter clock cycles from start
    // ------------------------------------------------------------------
    localparam logic [4:0] NORMAL_CONV_TICKS = 5'h0d;
    localparam logic [4:0] FIRST_CONV_TICKS = 5'h19;
    localparam logic [4:0] NORMAL_HOLD_TICK = 5'h01;
    localparam logic [4:0] FIRST_HOLD_TICK = 5'h0d;
    // ------------------------------------------------------------------
    // Reference choices
    // ------------------------------------------------------------------
    localparam logic [1:0] REF_EXT_PIN = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_RESERVED = 2'h2;
    localparam logic [1:0] REF_INTERNAL = 2'h3;
    // ------------------------------------------------------------------
    // Channel map and gains
    // ------------------------------------------------------------------
    localparam logic [4:0] DIFF_FIRST = 5'h08;
    localparam logic [4:0] DIFF_GAIN_LAST = 5'h0f;
    localparam logic [4:0] DIFF_LAST = 5'h1d;
    localparam logic [1:0] GAIN_1X = 2'h0;
    localparam logic [1:0] GAIN_10X = 2'h1;
    localparam logic [1:0] GAIN_200X = 2'h2;
    // ------------------------------------------------------------------
    // Sleep modes that allow a noise-quiet conversion
    // ------------------------------------------------------------------
    localparam logic [2:0] SLEEP_IDLE = 3'h0;
    localparam logic [2:0] SLEEP_NOISE_RED = 3'h1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_SAR = 2'b10,
        ST_FINISH = 2'b11
    } conv_state_t;
endpackage : adc_ctrl_pkg

// ---- src/adc_result_ctrl.sv ----
// Purpose: Conversion sequencing, result formatting and sleep-started conversions
// Assumes: comp_in answers the trial on dac_code_out within one converter tick
// Notes:   All inputs are synchronous to core_clk_in
`timescale 1ns/10ps
`default_nettype none
module adc_result_ctrl #(
    parameter int PRESCALE_DIV = 2
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Software control bits
    input wire logic converter_enable_in,
    input wire logic start_write_in,
    input wire logic single_mode_in,
    input wire logic irq_enable_in,
    input wire logic flag_clear_in,
    input wire logic left_adjust_result_in,
    input wire logic [4:0] channel_select_in,
    input wire logic [1:0] ref_select_in,
    // Processor sleep interface
    input wire logic sleep_enter_in,
    input wire logic [2:0] sleep_mode_in,
    input wire logic cpu_halted_in,
    // Analog front end
    input wire logic comp_in,
    output logic [9:0] dac_code_out,
    output logic sample_hold_out,
    output logic diff_mode_out,
    output logic [1:0] gain_sel_out,
    output logic [4:0] channel_out,
    output logic [1:0] ref_sel_out,
    output logic converter_on_out,
    // Status and results
    output logic [7:0] result_low_byte_out,
    output logic [7:0] result_high_byte_out,
    output logic conversion_done_flag_out,
    output logic conversion_start_bit_out,
    output logic conv_irq_out,
    output logic wake_out
);
    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (PRESCALE_DIV < 2 || PRESCALE_DIV > 128) begin : g_bad_div
        $error("PRESCALE_DIV must lie in 2..128");
    end

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic is_diff(input logic [4:0] ch);
        is_diff = (ch >= adc_ctrl_pkg::DIFF_FIRST) && (ch <= adc_ctrl_pkg::DIFF_LAST);
    endfunction : is_diff

    function automatic logic [1:0] gain_of(input logic [4:0] ch);
        if (ch >= adc_ctrl_pkg::DIFF_FIRST && ch <= adc_ctrl_pkg::DIFF_GAIN_LAST) begin
            gain_of = ch[1] ? adc_ctrl_pkg::GAIN_200X : adc_ctrl_pkg::GAIN_10X;
        end else begin
            gain_of = adc_ctrl_pkg::GAIN_1X;
        end
    endfunction : gain_of

    // Returns {high byte, low byte}
    function automatic logic [15:0] fmt_bytes(input logic [9:0] code, input logic left);
        if (left) begin
            fmt_bytes = {code, 6'h00};
        end else begin
            fmt_bytes = {6'h00, code};
        end
    endfunction : fmt_bytes

    // ------------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------------
    adc_ctrl_pkg::conv_state_t state_reg;
    logic [6:0] presc_reg;
    logic tick;
    logic [4:0] tick_cnt_reg;
    logic [4:0] tick_cnt_next;
    logic [3:0] bit_idx_reg;
    logic first_pending_reg;
    logic conv_first_reg;
    logic [9:0] result_reg;
    logic [9:0] held_code_reg;
    logic noise_pend_reg;
    logic sleep_conv_reg;
    logic start_go;
    logic complete;
    logic [9:0] bit_mask;
    logic [9:0] trial_kept;
    logic [9:0] final_code;
    logic flag_next;

    assign tick = (presc_reg == 7'(PRESCALE_DIV - 1));
    assign tick_cnt_next = tick_cnt_reg + 5'h01;
    assign start_go = converter_enable_in && (state_reg == adc_ctrl_pkg::ST_IDLE) && conversion_start_bit_out;
    assign complete = (state_reg == adc_ctrl_pkg::ST_FINISH) && tick
        && (tick_cnt_next == (conv_first_reg ? adc_ctrl_pkg::FIRST_CONV_TICKS : adc_ctrl_pkg::NORMAL_CONV_TICKS));
    assign bit_mask = 10'h001 << bit_idx_reg;
    // Comparator low clears the trial bit; a stuck-high comparator ends at full scale
    assign trial_kept = comp_in ? dac_code_out : (dac_code_out & ~bit_mask);
    // Offset-binary engine output becomes two's complement by flipping the top bit
    assign final_code = diff_mode_out ? {~result_reg[9], result_reg[8:0]} : result_reg;
    assign flag_next = complete | (conversion_done_flag_out & ~flag_clear_in);

    // ------------------------------------------------------------------
    // Converter clock prescaler
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            presc_reg <= 7'h00;
        end else if (!converter_enable_in || tick) begin
            presc_reg <= 7'h00;
        end else begin
            presc_reg <= presc_reg + 7'h01;
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequencer and successive approximation
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= adc_ctrl_pkg::ST_IDLE;
            tick_cnt_reg <= 5'h00;
            bit_idx_reg <= 4'h0;
            dac_code_out <= adc_ctrl_pkg::CODE_ZERO;
            result_reg <= adc_ctrl_pkg::CODE_ZERO;
            sample_hold_out <= 1'b0;
            conv_first_reg <= 1'b0;
        end else if (!converter_enable_in) begin
            // Turning off aborts any conversion in progress
            state_reg <= adc_ctrl_pkg::ST_IDLE;
            sample_hold_out <= 1'b0;
        end else begin
            sample_hold_out <= 1'b0;
            unique case (state_reg)
                adc_ctrl_pkg::ST_IDLE: begin
                    if (start_go) begin
                        state_reg <= adc_ctrl_pkg::ST_HOLD;
                        tick_cnt_reg <= 5'h00;
                        conv_first_reg <= first_pending_reg;
                    end
                end
                adc_ctrl_pkg::ST_HOLD: begin
                    if (tick) begin
                        tick_cnt_reg <= tick_cnt_next;
                        if (tick_cnt_next == (conv_first_reg ? adc_ctrl_pkg::FIRST_HOLD_TICK
                                                             : adc_ctrl_pkg::NORMAL_HOLD_TICK)) begin
                            state_reg <= adc_ctrl_pkg::ST_SAR;
                            sample_hold_out <= 1'b1;
                            dac_code_out <= adc_ctrl_pkg::SAR_FIRST_TRIAL;
                            bit_idx_reg <= adc_ctrl_pkg::SAR_TOP_BIT;
                        end
                    end
                end
                adc_ctrl_pkg::ST_SAR: begin
                    if (tick) begin
                        tick_cnt_reg <= tick_cnt_next;
                        dac_code_out <= trial_kept | (bit_mask >> 1);
                        bit_idx_reg <= bit_idx_reg - 4'h1;
                        if (bit_idx_reg == 4'h0) begin
                            result_reg <= trial_kept;
                            state_reg <= adc_ctrl_pkg::ST_FINISH;
                        end
                    end
                end
                adc_ctrl_pkg::ST_FINISH: begin
                    if (tick) begin
                        tick_cnt_reg <= tick_cnt_next;
                        if (complete) begin
                            state_reg <= adc_ctrl_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // First-conversion tracking
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            first_pending_reg <= 1'b1;
        end else if (!converter_enable_in) begin
            first_pending_reg <= 1'b1;
        end else if (start_go) begin
            first_pending_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Channel and reference selection, locked while converting
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            channel_out <= 5'h00;
            ref_sel_out <= adc_ctrl_pkg::REF_EXT_PIN;
            diff_mode_out <= 1'b0;
            gain_sel_out <= adc_ctrl_pkg::GAIN_1X;
            converter_on_out <= 1'b0;
        end else begin
            converter_on_out <= converter_enable_in;
            if (state_reg == adc_ctrl_pkg::ST_IDLE && !start_go) begin
                channel_out <= channel_select_in;
                diff_mode_out <= is_diff(channel_select_in);
                gain_sel_out <= gain_of(channel_select_in);
                // Reserved code is ignored so the pads never see an undefined source
                if (ref_select_in != adc_ctrl_pkg::REF_RESERVED) begin
                    ref_sel_out <= ref_select_in;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Start bit, done flag and interrupt request
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            conversion_start_bit_out <= 1'b0;
        end else if (!converter_enable_in) begin
            conversion_start_bit_out <= 1'b0;
        end else if (start_write_in || (noise_pend_reg && cpu_halted_in)) begin
            conversion_start_bit_out <= 1'b1;
        end else if (complete && single_mode_in) begin
            conversion_start_bit_out <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            conversion_done_flag_out <= 1'b0;
            conv_irq_out <= 1'b0;
        end else begin
            // Completion wins over a clear arriving in the same cycle
            conversion_done_flag_out <= flag_next;
            conv_irq_out <= flag_next & irq_enable_in;
        end
    end

    // ------------------------------------------------------------------
    // Result bytes, reformatted every cycle so left adjust acts at once
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            {result_high_byte_out, result_low_byte_out} <= adc_ctrl_pkg::BYTES_RESET;
        end else if (complete) begin
            {result_high_byte_out, result_low_byte_out} <= fmt_bytes(final_code, left_adjust_result_in);
        end else begin
            {result_high_byte_out, result_low_byte_out} <= fmt_bytes(held_code_reg, left_adjust_result_in);
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            held_code_reg <= adc_ctrl_pkg::CODE_ZERO;
        end else if (complete) begin
            held_code_reg <= final_code;
        end
    end

    // ------------------------------------------------------------------
    // Noise-quiet conversion during sleep
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            noise_pend_reg <= 1'b0;
            sleep_conv_reg <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            wake_out <= complete && sleep_conv_reg && cpu_halted_in;
            if (sleep_enter_in) begin
                // Only a fresh sleep entry can arm another conversion
                noise_pend_reg <= converter_enable_in && !conversion_start_bit_out && single_mode_in
                    && irq_enable_in && (state_reg == adc_ctrl_pkg::ST_IDLE)
                    && (sleep_mode_in == adc_ctrl_pkg::SLEEP_IDLE
                        || sleep_mode_in == adc_ctrl_pkg::SLEEP_NOISE_RED);
            end else if (noise_pend_reg && cpu_halted_in) begin
                noise_pend_reg <= 1'b0;
            end else if (!converter_enable_in) begin
                noise_pend_reg <= 1'b0;
            end
            if (noise_pend_reg && cpu_halted_in) begin
                sleep_conv_reg <= 1'b1;
            end else if (complete || !converter_enable_in) begin
                // An earlier wake leaves the conversion running; only its flag remains
                sleep_conv_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb_core @(posedge core_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_sleep_armed;
        noise_pend_reg && cpu_halted_in && converter_enable_in;
    endsequence
    sequence s_conv_running;
        conversion_start_bit_out ##1 (state_reg != adc_ctrl_pkg::ST_IDLE);
    endsequence

    property p_done_sets_flag;
        complete |=> conversion_done_flag_out && (held_code_reg == $past(final_code));
    endproperty
    a_done_sets_flag: assert property (p_done_sets_flag) else $error("done flag or result missed");
    property p_single_clears_start;
        complete && single_mode_in && !start_write_in |=> !conversion_start_bit_out;
    endproperty
    a_single_clears_start: assert property (p_single_clears_start) else $error("start bit kept");
    property p_bytes_with_flag;
        $rose(conversion_done_flag_out) |->
            {result_high_byte_out, result_low_byte_out} == fmt_bytes(held_code_reg, $past(left_adjust_result_in));
    endproperty
    a_bytes_with_flag: assert property (p_bytes_with_flag) else $error("result late vs flag");
    property p_left_low_zero;
        $past(left_adjust_result_in) |-> result_low_byte_out[5:0] == 6'h00;
    endproperty
    a_left_low_zero: assert property (p_left_low_zero) else $error("left form low bits");
    property p_right_high_zero;
        !$past(left_adjust_result_in) |-> result_high_byte_out[7:2] == 6'h00;
    endproperty
    a_right_high_zero: assert property (p_right_high_zero) else $error("right form high bits");
    property p_diff_sign;
        complete && diff_mode_out |=>
            (($past(left_adjust_result_in) ? result_high_byte_out[7] : result_high_byte_out[1])
                == ~$past(result_reg[9]));
    endproperty
    a_diff_sign: assert property (p_diff_sign) else $error("differential sign wrong");
    property p_sleep_start;
        s_sleep_armed |-> ##1 s_conv_running;
    endproperty
    a_sleep_start: assert property (p_sleep_start) else $error("sleep conversion not started");
    property p_wake_cause;
        wake_out |-> conversion_done_flag_out && $past(sleep_conv_reg, 1);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("spurious wake");
    property p_early_wake_irq;
        complete && sleep_conv_reg && !cpu_halted_in |=> conversion_done_flag_out && !wake_out;
    endproperty
    a_early_wake_irq: assert property (p_early_wake_irq) else $error("early wake lost flag");
    property p_other_sleep;
        sleep_enter_in && sleep_mode_in > adc_ctrl_pkg::SLEEP_NOISE_RED |=> !noise_pend_reg;
    endproperty
    a_other_sleep: assert property (p_other_sleep) else $error("armed in other sleep");
endmodule : adc_result_ctrl
`default_nettype wire

// ---- testbench/cpu_front_model.sv ----
// Purpose: Processor halt and comparator model facing the converter control
// Assumes: level_in is the analog input as an 11-bit code, above 0x3ff means over range
// Notes:   Differential inputs are given in offset form, difference plus 0x200
`timescale 1ns/10ps
`default_nettype none
module cpu_front_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Bench stimulus
    input wire logic [10:0] level_in,
    input wire logic sleep_enter_in,
    input wire logic other_irq_in,
    // Converter side
    input wire logic [9:0] dac_code_in,
    input wire logic sample_hold_in,
    input wire logic wake_in,
    output logic comp_out,
    output logic cpu_halted_out
);
    logic [10:0] held_reg;
    // Input frozen at sample time, as the hold capacitor would keep it
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            held_reg <= 11'h000;
        else if (sample_hold_in)
            held_reg <= level_in;
    end
    assign comp_out = ((sample_hold_in ? level_in : held_reg) >= {1'b0, dac_code_in});
    // Only a new sleep halts the core again after any wake
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            cpu_halted_out <= 1'b0;
        else if (wake_in || other_irq_in)
            cpu_halted_out <= 1'b0;
        else if (sleep_enter_in)
            cpu_halted_out <= 1'b1;
    end
endmodule : cpu_front_model
`default_nettype wire

// ---- testbench/adc_result_ctrl_test.sv ----
// Purpose: Self-checking bench for result formatting and sleep-started conversions
// Assumes: Prescaler at its fastest setting, so a first conversion ends within 60 cycles
// Notes:   Level is held steady during every conversion, as shared pins must be
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module adc_result_ctrl_test;
    logic clk = 0, rst_n = 0, en = 0, start = 0, single = 1, irqen = 0, fclr = 0, left = 0;
    logic sleep_en = 0, oirq = 0, comp, halted, sh, flag, sbit, irq, wake, con, dmode;
    logic [4:0] chan = 5'h00, chsel;
    logic [1:0] refs = 2'h0, rsel, gsel;
    logic [2:0] smode = 3'h0;
    logic [10:0] level = 11'h000;
    logic [9:0] dac;
    logic [7:0] lo, hi;
    int num_errors = 0, samples_checked = 0, cyc = 0;
    always #2 clk = ~clk;
    adc_result_ctrl #(.PRESCALE_DIV(2)) i_adc_result_ctrl (.core_clk_in(clk), .reset_n_in(rst_n),
        .converter_enable_in(en), .start_write_in(start), .single_mode_in(single),
        .irq_enable_in(irqen), .flag_clear_in(fclr), .left_adjust_result_in(left),
        .channel_select_in(chan), .ref_select_in(refs), .sleep_enter_in(sleep_en),
        .sleep_mode_in(smode), .cpu_halted_in(halted), .comp_in(comp), .dac_code_out(dac),
        .sample_hold_out(sh), .diff_mode_out(dmode), .gain_sel_out(gsel), .channel_out(chsel),
        .ref_sel_out(rsel), .converter_on_out(con), .result_low_byte_out(lo),
        .result_high_byte_out(hi), .conversion_done_flag_out(flag),
        .conversion_start_bit_out(sbit), .conv_irq_out(irq), .wake_out(wake));
    cpu_front_model i_cpu_front_model (.clk_in(clk), .reset_n_in(rst_n), .level_in(level),
        .sleep_enter_in(sleep_en), .other_irq_in(oirq), .dac_code_in(dac),
        .sample_hold_in(sh), .wake_in(wake), .comp_out(comp), .cpu_halted_out(halted));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic wait_flag;
        int n;
        n = 0;
        while (flag !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        `CHK("flag", 1'b1, flag)
        `CHK("start_bit", 1'b0, sbit)
    endtask : wait_flag
    task automatic clear_flag;
        fclr = 1;
        step(1);
        fclr = 0;
        step(1);
    endtask : clear_flag
    // Level stays put until completion so nothing toggles mid-conversion
    task automatic conv(input logic [10:0] lv, input logic [4:0] ch, input logic [15:0] ex);
        level = lv;
        chan = ch;
        start = 1;
        step(1);
        start = 0;
        wait_flag();
        `CHK("result", ex, {hi, lo})
        clear_flag();
    endtask : conv
    task automatic t_single;
        left = 0;
        conv(11'h2a5, 5'h00, 16'h02a5);
        `CHK("diff_mode_se", 1'b0, dmode)
        `CHK("gain_se", 2'h0, gsel)
        conv(11'h000, 5'h01, 16'h0000);
        conv(11'h4ff, 5'h02, 16'h03ff);
        $display("test single done");
    endtask : t_single
    task automatic t_diff;
        left = 1;
        conv(11'h070, 5'h0d, 16'h9c00);
        left = 0;
        step(2);
        `CHK("right_form", 16'h0270, {hi, lo})
        conv(11'h200, 5'h10, 16'h0000);
        conv(11'h3ff, 5'h10, 16'h01ff);
        $display("test diff done");
    endtask : t_diff
    // Free running keeps the start bit up and restarts after each completion
    task automatic t_free;
        single = 0;
        level = 11'h0aa;
        chan = 5'h00;
        start = 1;
        step(1);
        start = 0;
        repeat (2) begin
            for (int n = 0; n < 100 && flag !== 1'b1; n++) begin
                step(1);
            end
            `CHK("free_flag", 1'b1, flag)
            `CHK("free_start_bit", 1'b1, sbit)
            `CHK("free_result", 16'h00aa, {hi, lo})
            clear_flag();
        end
        en = 0;
        step(1);
        `CHK("abort_start_bit", 1'b0, sbit)
        en = 1;
        single = 1;
        $display("test free done");
    endtask : t_free
    task automatic t_refs;
        logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
        chan = 5'h0e;
        foreach (codes[i]) begin
            refs = codes[i];
            step(3);
            `CHK("ref", codes[i], rsel)
        end
        `CHK("gain", 2'h2, gsel)
        `CHK("diff_mode", 1'b1, dmode)
        `CHK("channel", 5'h0e, chsel)
        refs = 2'h2;
        step(3);
        `CHK("ref_kept", 2'h3, rsel)
        refs = 2'h1;
        // First result after a reference switch is thrown away unread
        start = 1;
        step(1);
        start = 0;
        wait_flag();
        clear_flag();
        $display("test refs done");
    endtask : t_refs
    task automatic go_sleep(input logic [2:0] m);
        smode = m;
        sleep_en = 1;
        step(1);
        sleep_en = 0;
    endtask : go_sleep
    task automatic t_sleep;
        irqen = 1;
        level = 11'h155;
        chan = 5'h00;
        for (int m = 0; m < 2; m++) begin
            go_sleep(m[2:0]);
            wait_flag();
            `CHK("wake", 1'b1, wake)
            `CHK("irq", 1'b1, irq)
            `CHK("result", 16'h0155, {hi, lo})
            clear_flag();
            `CHK("awake", 1'b0, halted)
        end
        go_sleep(3'h2);
        step(80);
        `CHK("no_conv", 1'b0, flag)
        `CHK("still_on", 1'b1, con)
        oirq = 1;
        step(1);
        oirq = 0;
        // Converter stayed on through the other sleep, so cycle it before further use
        en = 0;
        step(1);
        `CHK("off", 1'b0, con)
        en = 1;
        go_sleep(3'h1);
        step(10);
        oirq = 1;
        step(1);
        oirq = 0;
        wait_flag();
        `CHK("early_wake", 1'b0, wake)
        `CHK("late_irq", 1'b1, irq)
        clear_flag();
        step(60);
        `CHK("no_restart", 1'b0, sbit)
        $display("test sleep done");
    endtask : t_sleep
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        step(2);
        rst_n = 1;
        en = 1;
        t_refs();
        t_single();
        t_diff();
        t_free();
        t_sleep();
        results();
    end
endmodule : adc_result_ctrl_test
`default_nettype wire
